// >>> tb_top.sv
// self-checking bench of the calendar switch against a date range model
`timescale 1ns/1ps
`include "ycts_regs.svh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, en, out, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cw;
  logic [31:0] on_w [4];
  logic [31:0] off_w [4];
  logic [3:0] pstrb;
  logic [4:0] day;
  logic [3:0] month;
  logic [6:0] year;
  bit [31:0] seed = 32'h0000_0001;
  int miscompares, n_compared, eo, prev, a;
  ycts_cal_model i_cal (.pclk(pclk), .day(day), .month(month), .year(year));
  ycts_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cal_day_in(day), .cal_month_in(month),
    .cal_year_in(year), .block_enable_in(en), .range_active_out(out));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  function automatic int rnd(input int n);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed % n);
  endfunction
  function automatic logic [31:0] mk(input int e, input int s, y, m, d);
    return {1'(e), 7'h00, 1'(s), 7'(y), 4'h0, 4'(m), 3'h0, 5'(d)};
  endfunction
  // date key over the fields set in the on word
  function automatic int key(input logic [31:0] f, input logic [31:0] w);
    return (f[23] ? int'(w[22:16]) : 0) * 512 + (f[11:8] != 0 ? int'(w[11:8]) : 0) * 32
      + (f[4:0] != 0 ? int'(w[4:0]) : 0);
  endfunction
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      miscompares++;
      report_and_stop();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic cfg(input int n, input logic [31:0] on, input logic [31:0] off);
    on_w[n] = on;
    off_w[n] = off;
    apb(1'b1, 12'(`YCTS_ADDR_CH_BASE + 8 * n), on);
    apb(1'b1, 12'(`YCTS_ADDR_CH_BASE + 8 * n + 4), off);
    apb(1'b0, 12'(`YCTS_ADDR_CH_BASE + 8 * n), 0);
    chk(rd, on);
  endtask
  task automatic step(input logic rel);
    int cur;
    cur = 0;
    repeat (410) @(posedge pclk);
    cw = {9'h000, year, 4'h0, month, 3'h0, day};
    for (int i = 0; i < 4; i++) begin
      if (on_w[i][31] && key(on_w[i], on_w[i]) <= key(on_w[i], cw)
          && key(on_w[i], cw) <= key(on_w[i], off_w[i])) cur |= 1 << i;
    end
    if (rel && !en) begin
      eo = 0;
      prev = 0;
    end else begin
      if ((prev & ~cur) != 0) eo = 0;
      else if ((cur & ~prev) != 0) eo = 1;
      if (cur == 0) eo = 0;
      prev = cur;
    end
    chk(32'(out), 32'(eo));
    apb(1'b0, `YCTS_ADDR_STATUS, 0);
    chk(32'({rd[5], rd[0]}), 32'({!rel || en, eo[0]}));
    chk(32'(rd[4:1]), 32'(prev[3:0]));
    apb(1'b0, `YCTS_ADDR_DATE, 0);
    chk(rd, cw);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, en} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    {miscompares, n_compared, eo, prev} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `YCTS_ADDR_CH_BASE, 0);
    chk(rd, `YCTS_CH_RESET);
    apb(1'b0, 12'h030, 0);
    chk(rd, 32'h0000_0000);
    chk(32'(err), 1);
    apb(1'b1, `YCTS_ADDR_STATUS, 0);
    chk(32'(err), 1);
    apb(1'b1, `YCTS_ADDR_CTRL, 32'h0000_0004);
    apb(1'b1, `YCTS_ADDR_CH_BASE, 32'h8000_0100);
    chk(32'(err), 1);
    apb(1'b1, `YCTS_ADDR_CTRL, 32'h0000_0007);
    pstrb <= 4'he;
    apb(1'b1, `YCTS_ADDR_CTRL, 32'h0000_0000);
    pstrb <= 4'hf;
    apb(1'b0, `YCTS_ADDR_CTRL, 0);
    chk(rd, 32'h0000_0007);
    a = rnd(5);
    cfg(0, mk(1, 1, 20 + a, 0, 0), mk(0, 1, 21 + a + rnd(3), 0, 0));
    a = 1 + rnd(6);
    cfg(1, mk(1, 0, 0, a, 0), mk(0, 0, 0, a + rnd(6), 0));
    a = 1 + rnd(14);
    cfg(2, mk(1, 0, 0, 0, a), mk(0, 0, 0, 0, a + rnd(14)));
    a = 20 + rnd(5);
    cfg(3, mk(1, 1, a, 1 + rnd(12), 1 + rnd(28)),
        mk(0, 1, a + 1, 1 + rnd(12), 1 + rnd(28)));
    for (int ph = 0; ph < 2; ph++) begin
      if (ph == 1) apb(1'b1, `YCTS_ADDR_CTRL, 32'h0000_0006);
      for (int s = 0; s < 16; s++) begin
        en <= 1'(rnd(2));
        step(ph == 0);
        i_cal.set_date(1 + rnd(28), 1 + rnd(12), 20 + rnd(10));
        step(ph == 0);
      end
    end
    report_and_stop();
  end
endmodule

// >>> ycts_cal_model.sv
// calendar clock model that drives the current date
`timescale 1ns/1ps
module ycts_cal_model (
  // clock
  input wire logic pclk,
  // current date
  output logic [4:0] day,
  output logic [3:0] month,
  output logic [6:0] year
);
  task automatic set_date(input int d, input int m, input int y);
    @(posedge pclk);
    day <= 5'(d);
    month <= 4'(m);
    year <= 7'(y % 100);
  endtask
  initial begin
    day = 5'h01;
    month = 4'h1;
    year = 7'h14;
  end
endmodule

// >>> ycts_channel.sv
// one switching channel: compares the current date against its on and off dates
`timescale 1ns/1ps
`include "ycts_regs.svh"
module ycts_channel
  import ycts_pkg::*;
(
  // channel settings
  input wire logic [31:0] on_cfg,
  input wire logic [31:0] off_cfg,
  // current date
  input wire ycts_day_type cur_day,
  input wire ycts_month_type cur_month,
  input wire ycts_year_type cur_year,
  // result
  output logic in_range,
  output ycts_kind_type kind
);

  logic dm;
  logic mm;
  logic ym;
  ycts_key_type lo;
  ycts_key_type hi;
  ycts_key_type cur;

  always_comb begin
    // field set is taken from the on date; off uses the same fields
    dm = on_cfg[`YCTS_DAY_LSB +: 5] != 5'h00;
    mm = on_cfg[`YCTS_MONTH_LSB +: 4] != 4'h0;
    ym = on_cfg[`YCTS_YEAR_SET_BIT];
    lo = ycts_key(on_cfg[`YCTS_DAY_LSB +: 5], on_cfg[`YCTS_MONTH_LSB +: 4],
                  on_cfg[`YCTS_YEAR_LSB +: 7], dm, mm, ym);
    hi = ycts_key(off_cfg[`YCTS_DAY_LSB +: 5], off_cfg[`YCTS_MONTH_LSB +: 4],
                  off_cfg[`YCTS_YEAR_LSB +: 7], dm, mm, ym);
    cur = ycts_key(cur_day, cur_month, cur_year, dm, mm, ym);
    // whole days inclusive: on at start of on date, off at start of day after off date
    in_range = on_cfg[`YCTS_CH_EN_BIT] && (dm || mm || ym)
               && (cur >= lo) && (cur <= hi);
    case ({dm, mm, ym})
      3'b001: kind = YCTS_KIND_YEAR;
      3'b010: kind = YCTS_KIND_MONTH;
      3'b100: kind = YCTS_KIND_DAY;
      3'b111: kind = YCTS_KIND_FULL;
      3'b000: kind = YCTS_KIND_NONE;
      default: kind = YCTS_KIND_MIXED;
    endcase
  end

endmodule

// >>> ycts_chk.sv
// bus and output checks of the calendar switch
`timescale 1ns/1ps
module ycts_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // release and output
  input wire logic block_enable_in,
  input wire logic range_active_out
);
  logic rel_q;
  logic rel_d;
  logic acc;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign acc = psel && penable && pready;
  // copy of the release bit
  always_comb begin
    rel_d = rel_q;
    if (acc && pwrite && paddr == 12'h000 && pstrb[0]) begin
      rel_d = pwdata[0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_q <= 1'b0;
    end else begin
      rel_q <= rel_d;
    end
  end
  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_rdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_ro_err;
    acc && pwrite && (paddr == 12'h004 || paddr == 12'h008) |-> pslverr;
  endproperty
  a_ro_err: assert property (p_ro_err) else $error("read-only write accepted");
  property p_ctrl_ok;
    acc && paddr == 12'h000 |-> !pslverr;
  endproperty
  a_ctrl_ok: assert property (p_ctrl_ok) else $error("control access refused");
  property p_release_off;
    (rel_q && !block_enable_in) [*5] |-> !range_active_out;
  endproperty
  a_release_off: assert property (p_release_off) else $error("output on while held");
  property p_out_steady;
    $changed(range_active_out) && !rel_q |=> $stable(range_active_out) [*8];
  endproperty
  a_out_steady: assert property (p_out_steady) else $error("output off scan");
endmodule
bind ycts_top ycts_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .block_enable_in(block_enable_in),
  .range_active_out(range_active_out));

// >>> ycts_end_marker.sv
// empty file kept out of the design
`timescale 1ns/1ps

// >>> ycts_pkg.sv
// types shared by the calendar switch modules
package ycts_pkg;

  typedef logic [4:0] ycts_day_type;
  typedef logic [3:0] ycts_month_type;
  typedef logic [6:0] ycts_year_type;
  typedef logic [15:0] ycts_key_type;

  typedef enum logic [2:0] {
    YCTS_KIND_NONE  = 3'b000,
    YCTS_KIND_YEAR  = 3'b001,
    YCTS_KIND_MONTH = 3'b010,
    YCTS_KIND_DAY   = 3'b011,
    YCTS_KIND_MIXED = 3'b100,
    YCTS_KIND_FULL  = 3'b101
  } ycts_kind_type;

  // date packed year-month-day, unspecified fields forced to zero
  function automatic ycts_key_type ycts_key(input ycts_day_type d, input ycts_month_type m,
                                            input ycts_year_type y, input logic dm,
                                            input logic mm, input logic ym);
    ycts_key_type k;
    k = {(ym ? y : 7'h00), (mm ? m : 4'h0), (dm ? d : 5'h00)};
    return k;
  endfunction

endpackage

// >>> ycts_regs.svh
// register offsets, field positions, reset values and timing counts of the calendar switch
`ifndef YCTS_REGS_SVH
`define YCTS_REGS_SVH

`define YCTS_ADDR_W 12
`define YCTS_ADDR_CTRL 12'h000
`define YCTS_ADDR_STATUS 12'h004
`define YCTS_ADDR_DATE 12'h008
`define YCTS_ADDR_CH_BASE 12'h010
`define YCTS_ADDR_CH_LAST 12'h02C
`define YCTS_NUM_CH 4

`define YCTS_CTRL_RELEASE_BIT 0
`define YCTS_CTRL_PERMIT_BIT 1
`define YCTS_CTRL_RUN_BIT 2
`define YCTS_CTRL_MASK 32'h0000_0007
`define YCTS_CTRL_RESET 32'h0000_0000
`define YCTS_CH_RESET 32'h0000_0000

`define YCTS_DAY_LSB 0
`define YCTS_MONTH_LSB 8
`define YCTS_YEAR_LSB 16
`define YCTS_YEAR_SET_BIT 23
`define YCTS_CH_EN_BIT 31
`define YCTS_CH_MASK 32'h80FF_0F1F

`define YCTS_STAT_OUT_BIT 0
`define YCTS_STAT_RANGE_LSB 1
`define YCTS_STAT_EN_BIT 5

`define YCTS_CLK_NS 5
`define YCTS_SCAN_NS 1000
`define YCTS_SCAN_CYCLES (`YCTS_SCAN_NS / `YCTS_CLK_NS)

`endif

// >>> ycts_top.sv
// calendar driven time switch with four channels and an apb register file
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "ycts_regs.svh"
module ycts_top
  import ycts_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // calendar clock date, years counted from 2000
  input wire logic [4:0] cal_day_in,
  input wire logic [3:0] cal_month_in,
  input wire logic [6:0] cal_year_in,
  // block release and switch output
  input wire logic block_enable_in,
  output logic range_active_out
);

  localparam int SCAN_W = 8;
  localparam logic [SCAN_W-1:0] SCAN_LAST = SCAN_W'(`YCTS_SCAN_CYCLES - 1);

  function automatic logic [31:0] ycts_strb(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic ycts_is_chan(input logic [11:0] a);
    return (a >= `YCTS_ADDR_CH_BASE) && (a <= `YCTS_ADDR_CH_LAST) && (a[1:0] == 2'b00);
  endfunction

  // register selects of the bus decoder
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_STAT = 3'h1;
  localparam logic [2:0] SEL_DATE = 3'h2;
  localparam logic [2:0] SEL_CHAN = 3'h3;
  localparam logic [2:0] SEL_NONE = 3'h4;

  // shared by the write path and the read answer
  function automatic logic [2:0] ycts_sel(input logic [11:0] a);
    logic [2:0] s;
    if (a == `YCTS_ADDR_CTRL) begin
      s = SEL_CTRL;
    end else if (a == `YCTS_ADDR_STATUS) begin
      s = SEL_STAT;
    end else if (a == `YCTS_ADDR_DATE) begin
      s = SEL_DATE;
    end else if (ycts_is_chan(a)) begin
      s = SEL_CHAN;
    end else begin
      s = SEL_NONE;
    end
    return s;
  endfunction

  // date word: day, month and year each in its own field
  function automatic logic [31:0] ycts_date_word(input ycts_day_type d, input ycts_month_type m,
                                                 input ycts_year_type y);
    return {9'h000, y, 4'h0, m, 3'h0, d};
  endfunction

  // input synchronisers
  logic [16:0] sync1_q;
  logic [16:0] sync1_d;
  logic [16:0] sync2_q;
  logic [16:0] sync2_d;
  logic [16:0] sync3_q;
  logic [16:0] sync3_d;

  always_comb begin
    sync1_d = {block_enable_in, cal_year_in, cal_month_in, cal_day_in};
    sync2_d = sync1_q;
    sync3_d = sync2_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 17'h0_0000;
      sync2_q <= 17'h0_0000;
      sync3_q <= 17'h0_0000;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
    end
  end

  ycts_day_type cur_day;
  ycts_month_type cur_month;
  ycts_year_type cur_year;
  logic en_sync;
  logic date_stable;

  always_comb begin
    cur_day = sync2_q[4:0];
    cur_month = sync2_q[8:5];
    cur_year = sync2_q[15:9];
    en_sync = sync2_q[16];
    // date bits cross as a group; accept only when two samples agree
    date_stable = sync2_q[15:0] == sync3_q[15:0];
  end

  // scan cycle divider
  logic [SCAN_W-1:0] scan_cnt_q;
  logic [SCAN_W-1:0] scan_cnt_d;
  logic scan_tick;

  always_comb begin
    scan_tick = scan_cnt_q == SCAN_LAST;
    scan_cnt_d = scan_tick ? '0 : scan_cnt_q + SCAN_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_cnt_q <= '0;
    end else begin
      scan_cnt_q <= scan_cnt_d;
    end
  end

  // registers
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] on_q [`YCTS_NUM_CH];
  logic [31:0] on_d [`YCTS_NUM_CH];
  logic [31:0] off_q [`YCTS_NUM_CH];
  logic [31:0] off_d [`YCTS_NUM_CH];
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  logic setup;
  logic access;
  logic [2:0] reg_sel;
  logic chan_lock;
  logic [1:0] ch_idx;
  logic block_en;
  logic [`YCTS_NUM_CH-1:0] in_range;
  logic range_q;
  logic [`YCTS_NUM_CH-1:0] prev_q;

  always_comb begin
    setup = psel && !penable;
    access = psel && penable && pready;
    reg_sel = ycts_sel(paddr);
    ch_idx = 2'((paddr - `YCTS_ADDR_CH_BASE) >> 3);
    // channel dates locked while running unless editing is permitted
    chan_lock = ctrl_q[`YCTS_CTRL_RUN_BIT] && !ctrl_q[`YCTS_CTRL_PERMIT_BIT];
    ctrl_d = ctrl_q;
    on_d = on_q;
    off_d = off_q;
    if (access && pwrite && !pslverr) begin
      if (reg_sel == SEL_CTRL) begin
        ctrl_d = ycts_strb(ctrl_q, pwdata, pstrb) & `YCTS_CTRL_MASK;
      end else if (reg_sel == SEL_CHAN) begin
        if (paddr[2]) begin
          off_d[ch_idx] = ycts_strb(off_q[ch_idx], pwdata, pstrb) & `YCTS_CH_MASK;
        end else begin
          on_d[ch_idx] = ycts_strb(on_q[ch_idx], pwdata, pstrb) & `YCTS_CH_MASK;
        end
      end
    end
  end

  // answer is prepared in the setup cycle, so access lasts one cycle
  always_comb begin
    pready_d = setup;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (setup) begin
      case (reg_sel)
        SEL_CTRL: begin
          prdata_d = ctrl_q;
        end
        SEL_STAT: begin
          pslverr_d = pwrite;
          prdata_d[`YCTS_STAT_OUT_BIT] = range_q;
          prdata_d[`YCTS_STAT_RANGE_LSB +: 4] = prev_q;
          prdata_d[`YCTS_STAT_EN_BIT] = block_en;
        end
        SEL_DATE: begin
          pslverr_d = pwrite;
          prdata_d = ycts_date_word(cur_day, cur_month, cur_year);
        end
        SEL_CHAN: begin
          pslverr_d = pwrite && chan_lock;
          prdata_d = paddr[2] ? off_q[ch_idx] : on_q[ch_idx];
        end
        default: begin
          pslverr_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `YCTS_CTRL_RESET;
      for (int i = 0; i < `YCTS_NUM_CH; i++) begin
        on_q[i] <= `YCTS_CH_RESET;
        off_q[i] <= `YCTS_CH_RESET;
      end
    end else begin
      ctrl_q <= ctrl_d;
      on_q <= on_d;
      off_q <= off_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // channels
  for (genvar g = 0; g < `YCTS_NUM_CH; g++) begin : g_ch
    ycts_channel u_ch (
      .on_cfg(on_q[g]),
      .off_cfg(off_q[g]),
      .cur_day(cur_day),
      .cur_month(cur_month),
      .cur_year(cur_year),
      .in_range(in_range[g]),
      .kind()
    );
  end

  // switch evaluation
  logic [`YCTS_NUM_CH-1:0] prev_d;
  logic range_d;
  logic on_evt;
  logic off_evt;

  always_comb begin
    block_en = !ctrl_q[`YCTS_CTRL_RELEASE_BIT] || en_sync;
    on_evt = |(in_range & ~prev_q);
    off_evt = |(~in_range & prev_q);
    prev_d = prev_q;
    range_d = range_q;
    if (!block_en) begin
      // stopped block forgets its history, nothing is retained
      prev_d = '0;
      range_d = 1'b0;
    end else if (scan_tick && date_stable) begin
      prev_d = in_range;
      if (off_evt || (in_range == '0)) begin
        range_d = 1'b0;
      end else if (on_evt) begin
        range_d = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= '0;
      range_q <= 1'b0;
      range_active_out <= 1'b0;
    end else begin
      prev_q <= prev_d;
      range_q <= range_d;
      range_active_out <= range_d;
    end
  end

endmodule
